// File: core/skdb_status_regs.sv
/*
  Status register, rate/limit configuration register and key debounce
  logic, reached over the 4-wire serial interface.
  Assumes all pins are synchronous to clk_in; analog events arrive as
  levels from the supply monitors and the mode controller.
*/
// Notes on behaviour
// - Rate code 00,01,10,11 scales extended tick by 8,4,2,1; default 10.
// - Upper limit gives (value-1) extended ticks; reset 28; below 12 unusable.
// - Status register sits at address 8, readable serially.
// - Interrupt on wake or aux flag setting, or key event.
// - Status read clears wake, low and aux flags and the interrupt.
// - Wake flag records wake pin rising edge; forces supply and clock enables.
// - Low-supply flag set while supply monitor reports low output.
// - Aux flag set on off-to-aux or idle battery-to-aux switch.
// - In off mode key falling edge asserts reset and powers supplies.
// - After key wake and supplies ready, set key bit and interrupt.
// - Key event in active modes clears and starts the debounce counter.
// - At 8195 divided ticks update key bits, interrupt, stop counter.
// - Repeat event on same key before terminal count stops counter.
// - Event on another key before terminal count restarts counter.
// - Running debounce counter forces supply and clock enables.
// - Key interrupt cleared by status read or interrupt-clear command.
// - Command 101xxxxx drives interrupt output low.
// - Read command is 010 plus five-bit address, MSB first.
`timescale 1ns/10ps
`default_nettype none
module skdb_status_regs
  import skdb_pkg::*;
(
  input wire logic clk_in, // System clock, 250 MHz
  input wire logic srst_in, // Synchronous reset, high
  input wire logic cs_in, // Serial chip select, high
  input wire logic sck_in, // Serial clock
  input wire logic sdi_in, // Serial data in
  output logic sdo_out, // Serial data out
  output logic sdo_oe_out, // Serial data out enable
  input wire skdb_mode_t mode_in, // Operating mode
  input wire logic [NUM_KEYS-1:0] key_input_in, // Key pins
  input wire logic wake_pin_in, // Wake pin
  input wire logic low_supply_in, // Ext supply below threshold
  input wire logic aux_source_in, // Running from aux supply
  input wire logic supplies_ready_in, // Core supply valid, oscillator settled
  input wire logic limit_multiplier_in, // Limit multiplier select
  output logic irq_out, // Interrupt, high
  output logic reset_n_out, // Reset to host, low active
  output logic core_supplies_on_out, // Digital, analog, ext supplies on
  output logic ext_supply_enable_force_out, // Forces ext supply enable
  output logic clk_out_enable_force_out, // Forces clock output enable
  output logic extended_tick_out, // Extended tick pulse
  output logic [5:0] max_pulse_ticks_out, // Upper pulse limit in ticks
  output skdb_cfg_t cfg_out, // Configuration register
  output skdb_status_t status_out // Status register
);
  typedef enum logic [1:0] {
    SER_CMD,
    SER_READ,
    SER_WRITE,
    SER_SKIP
  } skdb_ser_t;

  skdb_ser_t ser_state;
  skdb_cfg_t cfg;
  skdb_status_t status;
  logic [7:0] dclk_cnt;
  logic dclk_tick;
  logic [4:0] xt_cnt, xt_period;
  logic [4:0] ser_addr;
  logic byte_valid;
  logic [7:0] rx_byte;
  logic tx_load;
  logic [7:0] tx_data;
  logic status_read;
  logic del_irq;
  logic db_running, db_update;
  logic [NUM_KEYS-1:0] db_level;
  logic [NUM_KEYS-1:0] key_prev;
  logic [NUM_KEYS-1:0] wake_keys;
  logic wake_prev, aux_prev;
  logic wake_pending;
  logic active_mode;
  logic wake_rise, aux_rise, key_fall;
  logic irq_pending;
  logic [5:0] limit_eff;

  // Register read value; unmapped addresses read zero
  function automatic logic [7:0] read_value(input logic [4:0] addr,
                                            input skdb_cfg_t c,
                                            input skdb_status_t s);
    if (addr == ADDR_RATE_CFG) begin
      read_value = c;
    end else if (addr == ADDR_STATUS) begin
      read_value = s;
    end else begin
      read_value = 8'h00;
    end
  endfunction

  assign active_mode = (mode_in != MODE_OFF);
  assign wake_rise = wake_pin_in && !wake_prev;
  assign aux_rise = aux_source_in && !aux_prev;
  assign key_fall = |(key_prev & ~key_input_in);
  assign cfg_out = cfg;
  assign status_out = status;
  assign irq_out = irq_pending;
  assign sdo_oe_out = cs_in;

  // Divided clock enable
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      dclk_cnt <= '0;
      dclk_tick <= 1'b0;
    end else begin
      dclk_tick <= (dclk_cnt == DCLK_DIV_CYCLES - 8'h01);
      if (dclk_cnt == DCLK_DIV_CYCLES - 8'h01) begin
        dclk_cnt <= '0;
      end else begin
        dclk_cnt <= dclk_cnt + 8'h01;
      end
    end
  end

  // Extended tick: divided ticks times range factor times multiplier
  assign xt_period = limit_multiplier_in ? {range_mult(cfg.rate_range), 1'b0}
                                         : {1'b0, range_mult(cfg.rate_range)};

  always_ff @(posedge clk_in) begin
    extended_tick_out <= 1'b0;
    if (srst_in) begin
      xt_cnt <= '0;
    end else if (dclk_tick) begin
      if (xt_cnt + 5'h01 >= xt_period) begin
        xt_cnt <= '0;
        extended_tick_out <= 1'b1;
      end else begin
        xt_cnt <= xt_cnt + 5'h01;
      end
    end
  end

  // Values below the minimum are not usable; clamp to it
  assign limit_eff = (cfg.upper_limit < LIMIT_MIN) ? LIMIT_MIN : cfg.upper_limit;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      max_pulse_ticks_out <= LIMIT_RESET - 6'h01;
    end else begin
      max_pulse_ticks_out <= limit_eff - 6'h01;
    end
  end

  skdb_spi_shift u_shift (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .cs_in(cs_in),
    .sck_in(sck_in),
    .sdi_in(sdi_in),
    .load_in(tx_load),
    .load_data_in(tx_data),
    .byte_valid_out(byte_valid),
    .byte_out(rx_byte),
    .sdo_out(sdo_out)
  );

  skdb_key_debounce u_debounce (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .tick_in(dclk_tick),
    .enable_in(active_mode),
    .key_in(key_input_in),
    .running_out(db_running),
    .update_out(db_update),
    .level_out(db_level)
  );

  // Serial command decode and register access
  always_ff @(posedge clk_in) begin
    tx_load <= 1'b0;
    status_read <= 1'b0;
    del_irq <= 1'b0;
    if (srst_in) begin
      ser_state <= SER_CMD;
      ser_addr <= '0;
      tx_data <= '0;
      cfg <= '{rate_range: RATE_RESET, upper_limit: LIMIT_RESET};
    end else if (!cs_in) begin
      ser_state <= SER_CMD;
    end else if (byte_valid) begin
      unique case (ser_state)
        SER_CMD: begin
          ser_addr <= rx_byte[4:0];
          unique case (rx_byte[CMD_TYPE_MSB:CMD_TYPE_LSB])
            CMD_READ: begin
              ser_state <= SER_READ;
              tx_load <= 1'b1;
              tx_data <= read_value(rx_byte[4:0], cfg, status);
              status_read <= (rx_byte[4:0] == ADDR_STATUS);
            end
            CMD_WRITE: begin
              ser_state <= SER_WRITE;
              tx_load <= 1'b1;
              tx_data <= rx_byte;
            end
            CMD_DEL_IRQ: begin
              ser_state <= SER_SKIP;
              del_irq <= 1'b1;
            end
            default: begin
              ser_state <= SER_SKIP;
            end
          endcase
        end
        SER_READ: begin
          // Successive read of the next address
          ser_addr <= ser_addr + 5'h01;
          tx_load <= 1'b1;
          tx_data <= read_value(ser_addr + 5'h01, cfg, status);
          status_read <= (ser_addr + 5'h01 == ADDR_STATUS);
        end
        SER_WRITE: begin
          if (ser_addr == ADDR_RATE_CFG) begin
            cfg <= rx_byte;
          end
          ser_addr <= ser_addr + 5'h01;
          tx_load <= 1'b1;
          tx_data <= rx_byte;
        end
        SER_SKIP: begin
          ser_state <= SER_SKIP;
        end
      endcase
    end
  end

  // Edge history of the pins
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      key_prev <= '1;
      wake_prev <= 1'b0;
      aux_prev <= 1'b0;
    end else begin
      key_prev <= key_input_in;
      wake_prev <= wake_pin_in;
      aux_prev <= aux_source_in;
    end
  end

  // Wake from off mode and host reset
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wake_pending <= 1'b0;
      wake_keys <= '0;
      reset_n_out <= 1'b1;
    end else if (mode_in == MODE_OFF && !wake_pending && key_fall) begin
      wake_pending <= 1'b1;
      wake_keys <= key_prev & ~key_input_in;
      reset_n_out <= 1'b0;
    end else if (wake_pending && supplies_ready_in) begin
      wake_pending <= 1'b0;
      reset_n_out <= !low_supply_in;
    end else if (!reset_n_out && supplies_ready_in && !low_supply_in) begin
      reset_n_out <= 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      core_supplies_on_out <= 1'b0;
    end else begin
      core_supplies_on_out <= active_mode || wake_pending;
    end
  end

  // Status flags; a set in the same cycle as a clear wins
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      status <= '{wake: 1'b0, low_supply: 1'b0, aux_supply: 1'b0,
                  key_event_bit: '0};
    end else begin
      if (status_read) begin
        status.wake <= 1'b0;
        status.low_supply <= 1'b0;
        status.aux_supply <= 1'b0;
      end
      if (wake_rise) begin
        status.wake <= 1'b1;
      end
      if (low_supply_in) begin
        status.low_supply <= 1'b1;
      end
      if (aux_rise && (mode_in == MODE_OFF || mode_in == MODE_IDLE)) begin
        status.aux_supply <= 1'b1;
      end
      if (wake_pending && supplies_ready_in) begin
        status.key_event_bit <= wake_keys;
      end else if (db_update) begin
        status.key_event_bit <= ~db_level;
      end
    end
  end

  // Interrupt: raised on new wake and aux flags and key events
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      irq_pending <= 1'b0;
    end else if ((wake_rise && !status.wake) ||
                 (aux_rise && !status.aux_supply &&
                  (mode_in == MODE_OFF || mode_in == MODE_IDLE)) ||
                 db_update || (wake_pending && supplies_ready_in)) begin
      irq_pending <= 1'b1;
    end else if (status_read || del_irq) begin
      irq_pending <= 1'b0;
    end
  end

  // Forced enables while woken by the wake pin or debouncing
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ext_supply_enable_force_out <= 1'b0;
      clk_out_enable_force_out <= 1'b0;
    end else begin
      ext_supply_enable_force_out <= status.wake || db_running;
      clk_out_enable_force_out <= status.wake || db_running;
    end
  end
endmodule
`default_nettype wire

// File: common/skdb_pkg.sv
/*
  Shared types and constants for the status, key debounce and
  rate/limit configuration block.
  Assumes one 250 MHz clock and a synchronous active-high reset.
*/
package skdb_pkg;

  // Register addresses
  localparam logic [4:0] ADDR_RATE_CFG = 5'h05;
  localparam logic [4:0] ADDR_STATUS = 5'h08;

  // Command types, top three bits of the command byte
  localparam logic [2:0] CMD_READ = 3'h2;
  localparam logic [2:0] CMD_WRITE = 3'h3;
  localparam logic [2:0] CMD_DEL_IRQ = 3'h5;
  localparam int CMD_TYPE_MSB = 7;
  localparam int CMD_TYPE_LSB = 5;

  // Configuration register layout and reset values
  localparam int RATE_MSB = 7;
  localparam int RATE_LSB = 6;
  localparam int LIMIT_MSB = 5;
  localparam int LIMIT_LSB = 0;
  localparam logic [1:0] RATE_RESET = 2'h2;
  localparam logic [5:0] LIMIT_RESET = 6'h1C;
  localparam logic [5:0] LIMIT_MIN = 6'h0C;

  // Status register layout
  localparam int ST_WAKE = 7;
  localparam int ST_LOW = 6;
  localparam int ST_AUX = 5;
  localparam int ST_KEY_MSB = 4;
  localparam int ST_KEY_LSB = 0;

  // Divided tick: system cycles per divided clock period
  localparam logic [7:0] DCLK_DIV_CYCLES = 8'h08;
  // Debounce terminal count in divided clock periods (8195)
  localparam logic [13:0] DEBOUNCE_TERM = 14'h2003;
  localparam int NUM_KEYS = 5;
  localparam int SPI_BITS = 8;

  typedef enum logic [2:0] {
    MODE_OFF,
    MODE_IDLE,
    MODE_AUX,
    MODE_TX,
    MODE_RX,
    MODE_POLL
  } skdb_mode_t;

  typedef struct packed {
    logic [1:0] rate_range;
    logic [5:0] upper_limit;
  } skdb_cfg_t;

  typedef struct packed {
    logic wake;
    logic low_supply;
    logic aux_supply;
    logic [4:0] key_event_bit;
  } skdb_status_t;

  // Multiplier of the divided tick for each rate-range code
  function automatic logic [3:0] range_mult(input logic [1:0] code);
    unique case (code)
      2'h0: range_mult = 4'h8;
      2'h1: range_mult = 4'h4;
      2'h2: range_mult = 4'h2;
      default: range_mult = 4'h1;
    endcase
  endfunction

endpackage

// File: core/skdb_key_debounce.sv
/*
  Debounce counter for the five key inputs.
  Assumes tick_in is a one-cycle pulse once per divided clock period.
*/
`timescale 1ns/10ps
`default_nettype none
module skdb_key_debounce
  import skdb_pkg::*;
(
  input wire logic clk_in, // System clock
  input wire logic srst_in, // Synchronous reset
  input wire logic tick_in, // Divided clock enable
  input wire logic enable_in, // Active mode
  input wire logic [NUM_KEYS-1:0] key_in, // Key pins
  output logic running_out, // Counter running
  output logic update_out, // Terminal count pulse
  output logic [NUM_KEYS-1:0] level_out // Settled pin levels
);
  logic [NUM_KEYS-1:0] sync1, sync2, sync3, last_ev, ev;
  logic [13:0] count;

  assign ev = sync2 ^ sync3;

  // Sampled on the divided clock before edge detection
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sync1 <= '1;
      sync2 <= '1;
      sync3 <= '1;
    end else if (tick_in) begin
      sync1 <= key_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  always_ff @(posedge clk_in) begin
    update_out <= 1'b0;
    if (srst_in) begin
      running_out <= 1'b0;
      count <= '0;
      last_ev <= '0;
      level_out <= '1;
    end else if (!enable_in) begin
      running_out <= 1'b0;
    end else if (tick_in) begin
      if (ev != '0) begin
        if (running_out && ev == last_ev) begin
          running_out <= 1'b0;
        end else begin
          running_out <= 1'b1;
          count <= '0;
          last_ev <= ev;
        end
      end else if (running_out) begin
        if (count + 14'h0001 == DEBOUNCE_TERM) begin
          running_out <= 1'b0;
          update_out <= 1'b1;
          level_out <= sync2;
        end
        count <= count + 14'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// File: core/skdb_spi_shift.sv
/*
  Byte shifter for the 4-wire serial interface, MSB first.
  Assumes pins are synchronous to clk_in and far slower than it.
*/
`timescale 1ns/10ps
`default_nettype none
module skdb_spi_shift
  import skdb_pkg::*;
(
  input wire logic clk_in, // System clock
  input wire logic srst_in, // Synchronous reset
  input wire logic cs_in, // Chip select, high active
  input wire logic sck_in, // Serial clock
  input wire logic sdi_in, // Serial data in
  input wire logic load_in, // Load next output byte
  input wire logic [7:0] load_data_in, // Next output byte
  output logic byte_valid_out, // Byte received pulse
  output logic [7:0] byte_out, // Received byte
  output logic sdo_out // Serial data out
);
  logic sck_prev;
  logic [2:0] bit_cnt;
  logic [7:0] rx_sr, tx_sr;

  assign sdo_out = tx_sr[7];

  always_ff @(posedge clk_in) begin
    byte_valid_out <= 1'b0;
    if (srst_in || !cs_in) begin
      sck_prev <= 1'b0;
      bit_cnt <= '0;
      rx_sr <= '0;
      tx_sr <= '0;
      byte_out <= '0;
    end else begin
      sck_prev <= sck_in;
      if (sck_in && !sck_prev) begin
        rx_sr <= {rx_sr[6:0], sdi_in};
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'(SPI_BITS - 1)) begin
          byte_valid_out <= 1'b1;
          byte_out <= {rx_sr[6:0], sdi_in};
        end
      end
      if (load_in) begin
        tx_sr <= load_data_in;
      end else if (!sck_in && sck_prev && bit_cnt != 3'h0) begin
        tx_sr <= {tx_sr[6:0], 1'b0};
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/skdb_status_regs_checker.sv
/*
  Port assertions for the status, debounce and rate/limit block.
  Assumes one clock and the synchronous high reset of the block.
*/
`timescale 1ns/10ps
`default_nettype none
module skdb_status_regs_checker
  import skdb_pkg::*;
(
  input wire logic clk_in, // Clock
  input wire logic srst_in, // Reset
  input wire logic cs_in, // Chip select
  input wire logic sdo_oe_out, // Data out enable
  input wire skdb_mode_t mode_in, // Mode
  input wire logic [NUM_KEYS-1:0] key_input_in, // Keys
  input wire logic wake_pin_in, // Wake pin
  input wire logic low_supply_in, // Low supply
  input wire logic irq_out, // Interrupt
  input wire logic reset_n_out, // Host reset
  input wire logic ext_supply_enable_force_out, // Supply force
  input wire logic clk_out_enable_force_out, // Clock force
  input wire logic [5:0] max_pulse_ticks_out, // Pulse limit
  input wire skdb_cfg_t cfg_out, // Config
  input wire skdb_status_t status_out // Status
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);

  sequence s_wake_rise;
    $rose(wake_pin_in) && !status_out.wake && mode_in != MODE_OFF;
  endsequence
  sequence s_wake_set;
    irq_out && status_out.wake;
  endsequence
  sequence s_key_change;
    $changed(key_input_in) && mode_in != MODE_OFF;
  endsequence
  sequence s_forced;
    ext_supply_enable_force_out && clk_out_enable_force_out;
  endsequence

  property p_reset_vals;
    $fell(srst_in) |-> cfg_out == {RATE_RESET, LIMIT_RESET} && status_out == 8'h00 && !irq_out && reset_n_out;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
  property p_pulse_ticks;
    $stable(cfg_out.upper_limit) |->
      max_pulse_ticks_out == ((cfg_out.upper_limit < LIMIT_MIN) ? 6'h0B : cfg_out.upper_limit - 6'h01);
  endproperty
  a_pulse_ticks: assert property (p_pulse_ticks) else $error("pulse limit wrong");
  property p_oe;
    sdo_oe_out == cs_in;
  endproperty
  a_oe: assert property (p_oe) else $error("data out enable wrong");
  property p_wake;
    s_wake_rise |=> s_wake_set;
  endproperty
  a_wake: assert property (p_wake) else $error("wake flag not set");
  property p_wake_force;
    status_out.wake && $past(status_out.wake) |-> s_forced;
  endproperty
  a_wake_force: assert property (p_wake_force) else $error("wake force missing");
  property p_low;
    low_supply_in [*3] |=> status_out.low_supply;
  endproperty
  a_low: assert property (p_low) else $error("low flag not set");
  property p_flag_clear;
    $fell(status_out.wake) || $fell(status_out.aux_supply) || $fell(status_out.low_supply) |-> cs_in;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag cleared without access");
  property p_irq_clear;
    $fell(irq_out) |-> cs_in;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq cleared without access");
  property p_aux_irq;
    $rose(status_out.aux_supply) |-> irq_out;
  endproperty
  a_aux_irq: assert property (p_aux_irq) else $error("aux flag without irq");
  property p_key_irq;
    $changed(status_out.key_event_bit) |-> irq_out;
  endproperty
  a_key_irq: assert property (p_key_irq) else $error("key update without irq");
  property p_dbnc_force;
    s_key_change |-> ##[1:80] s_forced;
  endproperty
  a_dbnc_force: assert property (p_dbnc_force) else $error("debounce force missing");
endmodule
bind skdb_status_regs skdb_status_regs_checker chk_u (.clk_in, .srst_in, .cs_in, .sdo_oe_out, .mode_in,
  .key_input_in, .wake_pin_in, .low_supply_in, .irq_out, .reset_n_out, .ext_supply_enable_force_out,
  .clk_out_enable_force_out, .max_pulse_ticks_out, .cfg_out, .status_out);
`default_nettype wire

// File: testbench/skdb_host_model.sv
/*
  Host controller on the 4-wire serial interface.
  Assumes clk_in is the block clock; sck phases last four cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module skdb_host_model (
  input wire logic clk_in, // System clock
  input wire logic sdo_in, // Data from device
  output logic cs_out, // Chip select
  output logic sck_out, // Serial clock
  output logic sdi_out, // Data to device
  output logic rd_valid_out, // Reply ready
  output logic [7:0] rd_byte_out // Reply byte
);
  initial begin
    cs_out = 1'b0;
    sck_out = 1'b0;
    sdi_out = 1'b0;
    rd_valid_out = 1'b0;
    rd_byte_out = 8'h00;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sdi_out = tx[i];
      cyc(4);
      rx[i] = sdo_in;
      sck_out = 1'b1;
      cyc(4);
      sck_out = 1'b0;
    end
  endtask
  // Last byte reply is reported when rep is set
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat, input int nb, input bit rep);
    logic [7:0] rx;
    cs_out = 1'b1;
    shift_byte(cmd, rx);
    if (nb > 1) shift_byte(dat, rx);
    rd_byte_out = rx;
    rd_valid_out = rep;
    cyc(4);
    rd_valid_out = 1'b0;
    cs_out = 1'b0;
    sdi_out = ~sdi_out;
    cyc(4);
  endtask
endmodule
`default_nettype wire

// File: testbench/skdb_status_regs_bench.sv
/*
  Self-checking bench for the status and configuration block.
  Assumes the host model drives the serial pins.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; $display("FAIL %s exp %0h got %0h", n, e, g); end end
module skdb_status_regs_bench
  import skdb_pkg::*;
;
  logic clk_in = 1'b0;
  logic srst_in, cs, sck, sdi, sdo, sdo_oe, sdo_w, wake, low, aux, ready, lmul, irq, rst_n, sup_on;
  logic efrc, cfrc, xtick, rd_valid;
  logic [4:0] keys;
  logic [5:0] max_ticks;
  logic [7:0] rd_byte, exp_v;
  skdb_mode_t mode;
  skdb_cfg_t cfg;
  skdb_status_t status;
  int n_fail = 0;
  int tests_run = 0;
  logic [7:0] exp_q[$];
  string name_q[$];
  string exp_n;
  always #2 clk_in = ~clk_in;
  assign sdo_w = sdo_oe ? sdo : ~sdo;
  skdb_status_regs dut_u (.clk_in, .srst_in, .cs_in(cs), .sck_in(sck), .sdi_in(sdi), .sdo_out(sdo),
    .sdo_oe_out(sdo_oe), .mode_in(mode), .key_input_in(keys), .wake_pin_in(wake), .low_supply_in(low),
    .aux_source_in(aux), .supplies_ready_in(ready), .limit_multiplier_in(lmul), .irq_out(irq),
    .reset_n_out(rst_n), .core_supplies_on_out(sup_on), .ext_supply_enable_force_out(efrc),
    .clk_out_enable_force_out(cfrc), .extended_tick_out(xtick), .max_pulse_ticks_out(max_ticks),
    .cfg_out(cfg), .status_out(status));
  skdb_host_model host_u (.clk_in, .sdo_in(sdo_w), .cs_out(cs), .sck_out(sck), .sdi_out(sdi),
    .rd_valid_out(rd_valid), .rd_byte_out(rd_byte));
  // Reply checker: oldest note against each reply
  always @(posedge rd_valid) begin
    exp_n = name_q.pop_front();
    exp_v = exp_q.pop_front();
    `CHK(exp_n, exp_v, rd_byte)
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e, input string nm);
    name_q.push_back(nm);
    exp_q.push_back(e);
    host_u.xfer({CMD_READ, a}, 8'h00, 2, 1'b1);
  endtask
  task automatic tick_gap(output int g);
    for (int i = 0; i < 600 && xtick !== 1'b1; i++) cyc(1);
    g = 0;
    do begin
      cyc(1);
      g++;
    end while (xtick !== 1'b1 && g < 600);
  endtask
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk_in);
    n_fail++;
    print_verdict;
  end
  initial begin
    int g;
    logic [5:0] lim;
    g = $urandom(54780);
    srst_in = 1'b1;
    mode = MODE_IDLE;
    keys = 5'h1F;
    {wake, low, aux, lmul} = 4'h0;
    ready = 1'b1;
    cyc(8);
    srst_in = 1'b0;
    rd(ADDR_RATE_CFG, 8'h9C, "cfg reset");
    rd(ADDR_STATUS, 8'h00, "status reset");
    rd(5'h0F, 8'h00, "unmapped");
    `CHK("pulse limit", 6'h1B, max_ticks)
    for (int c = 0; c < 4; c++) begin
      lim = 6'(12 + $urandom % 52);
      lmul = 1'($urandom);
      host_u.xfer({CMD_WRITE, ADDR_RATE_CFG}, {2'(c), lim}, 2, 1'b0);
      rd(ADDR_RATE_CFG, {2'(c), lim}, "cfg readback");
      `CHK("pulse limit", lim - 6'h01, max_ticks)
      tick_gap(g);
      tick_gap(g);
      `CHK("tick gap", (8 >> c) * DCLK_DIV_CYCLES * (lmul ? 2 : 1), g)
    end
    host_u.xfer({CMD_WRITE, ADDR_RATE_CFG}, 8'h05, 2, 1'b0);
    rd(ADDR_RATE_CFG, 8'h05, "small limit");
    `CHK("clamped limit", 6'h0B, max_ticks)
    // Unused command type: data byte must not reach the register
    host_u.xfer(8'hC5, 8'hFF, 2, 1'b0);
    rd(ADDR_RATE_CFG, 8'h05, "unused cmd");
    wake = 1'b1;
    cyc(2);
    `CHK("wake irq", 1'b1, irq)
    `CHK("wake force", 2'h3, {efrc, cfrc})
    rd(ADDR_STATUS, 8'h80, "wake status");
    `CHK("irq after read", 1'b0, irq)
    wake = 1'b0;
    low = 1'b1;
    cyc(4);
    `CHK("low no irq", 1'b0, irq)
    rd(ADDR_STATUS, 8'h40, "low status");
    low = 1'b0;
    rd(ADDR_STATUS, 8'h40, "low held");
    rd(ADDR_STATUS, 8'h00, "low cleared");
    aux = 1'b1;
    cyc(2);
    `CHK("aux irq", 1'b1, irq)
    host_u.xfer({CMD_DEL_IRQ, 5'($urandom)}, 8'h00, 1, 1'b0);
    `CHK("deleted irq", 1'b0, irq)
    rd(ADDR_STATUS, 8'h20, "aux status");
    aux = 1'b0;
    mode = MODE_OFF;
    ready = 1'b0;
    keys = 5'h1E;
    for (int i = 0; i < 100 && rst_n !== 1'b0; i++) cyc(1);
    // Supplies flag follows the pending wake one cycle later
    cyc(1);
    `CHK("wake reset", 2'h1, {rst_n, sup_on})
    ready = 1'b1;
    for (int i = 0; i < 100 && irq !== 1'b1; i++) cyc(1);
    `CHK("key wake", 6'h21, {irq, status.key_event_bit})
    srst_in = 1'b1;
    keys = 5'h1F;
    mode = skdb_mode_t'(3'(1 + $urandom % 5));
    cyc(8);
    srst_in = 1'b0;
    cyc(100);
    keys = 5'h1B;
    for (int i = 0; i < 100 && efrc !== 1'b1; i++) cyc(1);
    `CHK("debounce force", 2'h3, {efrc, cfrc})
    keys = 5'h1F;
    cyc(200);
    `CHK("same key stop", 2'h0, {efrc, irq})
    keys = 5'h1B;
    cyc(1000);
    keys = 5'h19;
    cyc(8195 * int'(DCLK_DIV_CYCLES) - 900);
    `CHK("restart", 1'b0, irq)
    for (int i = 0; i < 1200 && irq !== 1'b1; i++) cyc(1);
    `CHK("debounce irq", 1'b1, irq)
    `CHK("key bits", 5'h06, status.key_event_bit)
    rd(ADDR_STATUS, 8'h06, "key status");
    `CHK("key irq read", 1'b0, irq)
    print_verdict;
  end
endmodule
`default_nettype wire
